// ### hw/iord_bank.sv
`timescale 1ns/1ps
`include "iord_params.svh"
module iord_bank
	import iord_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic ARST_N,
	input iord_req_t CORE_REQ,
	input wire logic SPI_DONE_SET,
	input wire logic SPI_COLL_SET,
	input wire logic CMP_EVENT_SET,
	input wire logic CMP_OUT,
	input wire logic RWW_BUSY,
	output iord_resp_t CORE_RESP,
	output logic [10:0] STACK_PTR,
	output logic [7:0] PROC_FLAGS,
	output logic [7:0] SPI_CONTROL
);
	// Storage covers the whole I/O window in data space; unmapped entries stay zero
	logic [7:0] bank [`IORD_IO_TO_DATA:`IORD_DATA_TOP];
	logic io_op;
	logic bit_op;
	logic rd_op;
	logic range_ok;
	logic hit;
	logic [7:0] daddr;
	logic [7:0] cur;
	logic [7:0] rd_val;
	logic [7:0] sel_bit;
	logic [7:0] next_val;
	logic wr_en;
	iord_mask_t msk;

	// Bit masks of each mapped register; all zero means reserved
	function automatic iord_mask_t mask_of(input logic [7:0] a);
		iord_mask_t m;
		m = '0;
		unique case (a)
			`IORD_TIMER0_COMPARE_A,
			`IORD_GENERAL_PURPOSE_ONE,
			`IORD_GENERAL_PURPOSE_TWO,
			`IORD_SERIAL_PERIPH_CONTROL,
			`IORD_SERIAL_PERIPH_BUFFER,
			`IORD_DEBUG_DATA_CHANNEL,
			`IORD_STACK_POINTER_LOW,
			`IORD_PROCESSOR_FLAGS,
			`IORD_OSCILLATOR_TRIM,
			`IORD_PIN_CHANGE_MASK_ZERO: m.rw = `IORD_RW_FULL;
			`IORD_SERIAL_PERIPH_FLAGS: begin
				m.rw = `IORD_RW_SERIAL_PERIPH_FLAGS;
				m.w1c = `IORD_W1C_SERIAL_PERIPH_FLAGS;
			end
			`IORD_COMPARATOR_CONTROL: begin
				m.rw = `IORD_RW_COMPARATOR_CONTROL;
				m.w1c = `IORD_W1C_COMPARATOR_CONTROL;
				m.live = 8'h01 << `IORD_LIVE_CMP_OUT_BIT;
			end
			`IORD_SLEEP_CONTROL: m.rw = `IORD_RW_SLEEP_CONTROL;
			`IORD_RESET_CAUSE_FLAGS: m.rw = `IORD_RW_RESET_CAUSE_FLAGS;
			`IORD_CORE_CONTROL: m.rw = `IORD_RW_CORE_CONTROL;
			`IORD_SELF_PROGRAM_CONTROL: begin
				m.rw = `IORD_RW_SELF_PROGRAM_CONTROL;
				m.live = 8'h01 << `IORD_LIVE_RWW_BUSY_BIT;
			end
			`IORD_STACK_POINTER_HIGH: m.rw = `IORD_RW_SPH;
			`IORD_WATCHDOG_CONTROL: m.rw = `IORD_RW_WATCHDOG_CONTROL;
			`IORD_CLOCK_DIVIDER_CONTROL: m.rw = `IORD_RW_CLOCK_DIVIDER_CONTROL;
			`IORD_POWER_GATING: m.rw = `IORD_RW_PRR;
			`IORD_EXT_IRQ_SENSE_CONFIG: m.rw = `IORD_RW_EXT_IRQ_SENSE_CONFIG;
			default: m = '0;
		endcase
		return m;
	endfunction

	// Address translation and range checks
	always_comb begin
		io_op = CORE_REQ.op inside {IORD_OP_IO_IN, IORD_OP_IO_OUT,
			set_single_io_bit_op, clear_single_io_bit_op};
		bit_op = CORE_REQ.op inside {set_single_io_bit_op, clear_single_io_bit_op};
		rd_op = CORE_REQ.op inside {IORD_OP_IO_IN, data_space_load_op};
		// I/O number lands 0x20 higher in data space, so it never reaches 0x60
		daddr = io_op ? ({2'b00, CORE_REQ.addr[5:0]} + `IORD_IO_TO_DATA) : CORE_REQ.addr; // R07 R08
		if (bit_op) begin
			range_ok = (CORE_REQ.addr <= `IORD_BIT_OP_TOP); // R05
		end else if (io_op) begin
			range_ok = (CORE_REQ.addr[7:6] == 2'b00); // R06
		end else begin
			range_ok = (CORE_REQ.addr >= `IORD_IO_TO_DATA);
		end
		msk = mask_of(daddr);
		hit = CORE_REQ.valid && range_ok && ((msk.rw | msk.w1c | msk.live) != 8'h00);
	end

	// Current contents with live status merged, reserved bits forced low
	always_comb begin
		cur = (daddr >= `IORD_IO_TO_DATA) ? bank[daddr] : 8'h00;
		rd_val = (cur & (msk.rw | msk.w1c)) | (msk.live & { // R09
			1'b0, RWW_BUSY, CMP_OUT, 5'b00000});
	end

	// New value of the target register for each kind of write
	always_comb begin
		sel_bit = 8'h01 << CORE_REQ.bit_idx;
		next_val = cur;
		wr_en = 1'b0;
		unique case (CORE_REQ.op)
			IORD_OP_IO_OUT,
			data_space_store_op: begin
				wr_en = hit;
				// Ones on flag positions clear, zeros leave the flag alone
				next_val = (CORE_REQ.wdata & msk.rw) | (cur & msk.w1c & ~CORE_REQ.wdata); // R03 R09
			end
			set_single_io_bit_op: begin
				wr_en = hit;
				// Only the addressed bit moves; a set on a flag counts as a one written
				next_val = (cur | (sel_bit & msk.rw)) & ~(sel_bit & msk.w1c); // R03 R04
			end
			clear_single_io_bit_op: begin
				wr_en = hit;
				next_val = cur & ~(sel_bit & msk.rw); // R04
			end
			default: begin
				wr_en = 1'b0;
				next_val = cur;
			end
		endcase
	end

	// Register bank; hardware flag sets come last so a same-cycle clear loses
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			for (int i = `IORD_IO_TO_DATA; i <= `IORD_DATA_TOP; i++) begin
				bank[i] <= `IORD_RESET_VAL;
			end
		end else begin
			if (wr_en) begin
				bank[daddr] <= next_val;
			end
			if (SPI_DONE_SET) begin
				bank[`IORD_SERIAL_PERIPH_FLAGS][`IORD_SPI_DONE_BIT] <= 1'b1; // R03
			end
			if (SPI_COLL_SET) begin
				bank[`IORD_SERIAL_PERIPH_FLAGS][`IORD_SPI_COLL_BIT] <= 1'b1;
			end
			if (CMP_EVENT_SET) begin
				bank[`IORD_COMPARATOR_CONTROL][`IORD_CMP_EVENT_BIT] <= 1'b1;
			end
		end
	end

	// Answer one cycle after every request; misses read zero
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			CORE_RESP <= '0;
		end else begin
			CORE_RESP.ack <= CORE_REQ.valid;
			CORE_RESP.refused <= CORE_REQ.valid && !hit; // R05 R06 R09
			CORE_RESP.rdata <= (hit && rd_op) ? rd_val : 8'h00;
		end
	end

	// Core-facing copies of registers the core itself consumes
	assign STACK_PTR = {bank[`IORD_STACK_POINTER_HIGH][2:0], bank[`IORD_STACK_POINTER_LOW]};
	assign PROC_FLAGS = bank[`IORD_PROCESSOR_FLAGS];
	assign SPI_CONTROL = bank[`IORD_SERIAL_PERIPH_CONTROL];

	// All checks share the one clock and sleep through reset
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!ARST_N);

	// A one written to the transfer-done flag clears it
	chk_flag_w1c: assert property ( // R03
		(CORE_REQ.valid && CORE_REQ.op == data_space_store_op
		&& CORE_REQ.addr == `IORD_SERIAL_PERIPH_FLAGS && CORE_REQ.wdata[7] && !SPI_DONE_SET)
		|=> !bank[`IORD_SERIAL_PERIPH_FLAGS][`IORD_SPI_DONE_BIT])
		else $error("flag not cleared by writing one");

	// Hardware set beats a same-cycle clear
	chk_flag_set_wins: assert property ( // R03
		SPI_DONE_SET |=> bank[`IORD_SERIAL_PERIPH_FLAGS][`IORD_SPI_DONE_BIT])
		else $error("flag set lost");

	// Guards any register later mapped in the bit range; none sits there today
	chk_bitop_isolate: assert property ( // R04
		(wr_en && bit_op && !SPI_DONE_SET && !SPI_COLL_SET && !CMP_EVENT_SET)
		|=> ((bank[$past(daddr)] ^ $past(cur)) & ~$past(sel_bit)) == 8'h00)
		else $error("bit operation touched other bits");

	// Bit operations above the low range are turned away
	chk_bitop_range: assert property ( // R05
		(CORE_REQ.valid && bit_op && CORE_REQ.addr > `IORD_BIT_OP_TOP)
		|=> CORE_RESP.ack && CORE_RESP.refused)
		else $error("bit operation above range accepted");

	// Dedicated I/O numbers carry six bits only
	chk_io_range: assert property ( // R06
		(CORE_REQ.valid && io_op && CORE_REQ.addr[7:6] != 2'b00) |=> CORE_RESP.refused)
		else $error("io address above 6 bits accepted");

	// Translation of the I/O number into data space
	chk_io_offset: assert property ( // R07
		io_op |-> daddr == ({2'b00, CORE_REQ.addr[5:0]} + `IORD_IO_TO_DATA))
		else $error("io offset wrong");

	// No I/O instruction may write past the I/O window
	chk_ext_unreach: assert property ( // R08
		(CORE_REQ.valid && io_op) |-> !(wr_en && daddr >= `IORD_EXT_BASE))
		else $error("extended range reached by io op");

	// Reads that hit nothing bring zero
	chk_rsvd_zero: assert property ( // R09
		(CORE_REQ.valid && rd_op && !hit) |=> CORE_RESP.rdata == 8'h00)
		else $error("reserved read not zero");

	// Nothing is written where nothing is mapped
	chk_rsvd_nowrite: assert property ( // R09
		(CORE_REQ.valid && !hit) |-> !wr_en)
		else $error("write to reserved location");

	// A one written to the collision flag clears it
	chk_coll_w1c: assert property ( // R03
		(CORE_REQ.valid && CORE_REQ.op == data_space_store_op && !SPI_COLL_SET
		&& CORE_REQ.addr == `IORD_SERIAL_PERIPH_FLAGS && CORE_REQ.wdata[`IORD_SPI_COLL_BIT])
		|=> !bank[`IORD_SERIAL_PERIPH_FLAGS][`IORD_SPI_COLL_BIT])
		else $error("collision flag not cleared by writing one");

	// Collision set pulse always lands
	chk_coll_set_wins: assert property ( // R03
		SPI_COLL_SET
		|=> bank[`IORD_SERIAL_PERIPH_FLAGS][`IORD_SPI_COLL_BIT])
		else $error("collision flag set lost");

	// A one written to the comparator event flag clears it
	chk_cmp_w1c: assert property ( // R03
		(CORE_REQ.valid && CORE_REQ.op == data_space_store_op && !CMP_EVENT_SET
		&& CORE_REQ.addr == `IORD_COMPARATOR_CONTROL
		&& CORE_REQ.wdata[`IORD_CMP_EVENT_BIT])
		|=> !bank[`IORD_COMPARATOR_CONTROL][`IORD_CMP_EVENT_BIT])
		else $error("comparator flag not cleared by writing one");

	// Comparator event pulse always lands
	chk_cmp_set_wins: assert property ( // R03
		CMP_EVENT_SET
		|=> bank[`IORD_COMPARATOR_CONTROL][`IORD_CMP_EVENT_BIT])
		else $error("comparator flag set lost");

	// A zero on a flag position leaves a set flag alone
	chk_flag_zero_keeps: assert property ( // R03
		(CORE_REQ.valid && CORE_REQ.op == data_space_store_op
		&& CORE_REQ.addr == `IORD_SERIAL_PERIPH_FLAGS && !CORE_REQ.wdata[`IORD_SPI_DONE_BIT]
		&& bank[`IORD_SERIAL_PERIPH_FLAGS][`IORD_SPI_DONE_BIT])
		|=> bank[`IORD_SERIAL_PERIPH_FLAGS][`IORD_SPI_DONE_BIT])
		else $error("flag cleared by writing zero");

	// A refused bit operation leaves the SPI control and processor flag copies alone
	chk_bitop_no_side: assert property ( // R05
		(CORE_REQ.valid && bit_op)
		|=> $stable(SPI_CONTROL) && $stable(PROC_FLAGS))
		else $error("bit operation changed a register");

	// An I/O read answers with the register seen in data space
	chk_io_alias_read: assert property ( // R07
		(CORE_REQ.valid && CORE_REQ.op == IORD_OP_IO_IN
		&& CORE_REQ.addr == `IORD_SERIAL_PERIPH_CONTROL - `IORD_IO_TO_DATA)
		|=> CORE_RESP.rdata == $past(SPI_CONTROL))
		else $error("io read not aliased to data space");

	// An I/O write lands in the register 0x20 higher in data space
	chk_io_alias_write: assert property ( // R07
		(CORE_REQ.valid && CORE_REQ.op == IORD_OP_IO_OUT
		&& CORE_REQ.addr == `IORD_PROCESSOR_FLAGS - `IORD_IO_TO_DATA)
		|=> PROC_FLAGS == $past(CORE_REQ.wdata))
		else $error("io write not aliased to data space");

	// A data-space store lands at its own address
	chk_data_store: assert property ( // R07
		(CORE_REQ.valid && CORE_REQ.op == data_space_store_op
		&& CORE_REQ.addr == `IORD_SERIAL_PERIPH_CONTROL)
		|=> SPI_CONTROL == $past(CORE_REQ.wdata))
		else $error("data store missed its register");

	// I/O instructions aimed at the extended range are turned away
	chk_ext_io_refused: assert property ( // R08
		(CORE_REQ.valid && io_op && CORE_REQ.addr >= `IORD_EXT_BASE)
		|=> CORE_RESP.refused)
		else $error("extended range accepted by io op");

	// Data-space stores do reach the extended range
	chk_ext_store: assert property ( // R08
		(CORE_REQ.valid && CORE_REQ.op == data_space_store_op
		&& CORE_REQ.addr == `IORD_OSCILLATOR_TRIM)
		|=> CORE_RESP.ack && !CORE_RESP.refused)
		else $error("extended store refused");

	// Data addresses below the I/O window belong to no register here
	chk_low_data_refused: assert property ( // R09
		(CORE_REQ.valid && (CORE_REQ.op == data_space_load_op
		|| CORE_REQ.op == data_space_store_op) && CORE_REQ.addr < `IORD_IO_TO_DATA)
		|=> CORE_RESP.refused)
		else $error("low data address accepted");

	// Reserved high bits of the stack pointer read as zero
	chk_rsvd_bits_zero: assert property ( // R09
		(CORE_REQ.valid && CORE_REQ.op == data_space_load_op
		&& CORE_REQ.addr == `IORD_STACK_POINTER_HIGH)
		|=> CORE_RESP.rdata[7:3] == 5'h00)
		else $error("reserved bits read nonzero");

	// Only the three live stack pointer bits take a store
	chk_sph_write: assert property ( // R09
		(CORE_REQ.valid && CORE_REQ.op == data_space_store_op
		&& CORE_REQ.addr == `IORD_STACK_POINTER_HIGH)
		|=> STACK_PTR[10:8] == $past(CORE_REQ.wdata[2:0]))
		else $error("stack pointer high byte not stored");

	// Reserved flag-register bits never hold a one
	chk_flag_rsvd_bits: assert property ( // R09
		(CORE_REQ.valid && CORE_REQ.op == data_space_store_op
		&& CORE_REQ.addr == `IORD_SERIAL_PERIPH_FLAGS)
		|=> bank[`IORD_SERIAL_PERIPH_FLAGS][5:1] == 5'h00)
		else $error("reserved flag bits stored");

	// A refusal rides on an answer and brings no data
	chk_refused_pulse: assert property ( // R09
		CORE_RESP.refused
		|-> CORE_RESP.ack && CORE_RESP.rdata == 8'h00)
		else $error("refusal without answer or with data");
endmodule

// ### hw/iord_params.svh
`ifndef IORD_PARAMS_SVH
`define IORD_PARAMS_SVH
// Contract
// R01 - Software never writes an I/O address marked reserved, so such writes need no defined effect.
// R02 - Software writes zero into reserved bit positions of any register it writes.
// R03 - Writing a one to a status flag clears that flag instead of storing the value.
// R04 - A single-bit set or clear changes only the addressed bit and rewrites no other bit.
// R05 - Single-bit set and clear are accepted only for I/O addresses 0x00 through 0x1F.
// R06 - Dedicated I/O in and out use a 6-bit I/O address from 0x00 to 0x3F, 64 locations.
// R07 - Through data-space load and store each I/O register appears at its I/O address plus 0x20.
// R08 - The extended range 0x60 to 0xFF is reachable only by data-space load and store.
// R09 - Reserved addresses and reserved bits read as zero and writes to them change nothing.

// Address map limits
`define IORD_IO_TO_DATA 8'h20
`define IORD_BIT_OP_TOP 8'h1F
`define IORD_EXT_BASE 8'h60
`define IORD_DATA_TOP 8'hFF
`define IORD_RESET_VAL 8'h00

// Register data addresses
`define IORD_TIMER0_COMPARE_A 8'h47
`define IORD_GENERAL_PURPOSE_ONE 8'h4A
`define IORD_GENERAL_PURPOSE_TWO 8'h4B
`define IORD_SERIAL_PERIPH_CONTROL 8'h4C
`define IORD_SERIAL_PERIPH_FLAGS 8'h4D
`define IORD_SERIAL_PERIPH_BUFFER 8'h4E
`define IORD_COMPARATOR_CONTROL 8'h50
`define IORD_DEBUG_DATA_CHANNEL 8'h51
`define IORD_SLEEP_CONTROL 8'h53
`define IORD_RESET_CAUSE_FLAGS 8'h54
`define IORD_CORE_CONTROL 8'h55
`define IORD_SELF_PROGRAM_CONTROL 8'h57
`define IORD_STACK_POINTER_LOW 8'h5D
`define IORD_STACK_POINTER_HIGH 8'h5E
`define IORD_PROCESSOR_FLAGS 8'h5F
`define IORD_WATCHDOG_CONTROL 8'h60
`define IORD_CLOCK_DIVIDER_CONTROL 8'h61
`define IORD_POWER_GATING 8'h64
`define IORD_OSCILLATOR_TRIM 8'h66
`define IORD_EXT_IRQ_SENSE_CONFIG 8'h69
`define IORD_PIN_CHANGE_MASK_ZERO 8'h6B

// Writable bit masks, reserved bits excluded
`define IORD_RW_FULL 8'hFF
`define IORD_RW_SERIAL_PERIPH_FLAGS 8'h01
`define IORD_RW_COMPARATOR_CONTROL 8'hCF
`define IORD_RW_SLEEP_CONTROL 8'h0F
`define IORD_RW_RESET_CAUSE_FLAGS 8'h1F
`define IORD_RW_CORE_CONTROL 8'h93
`define IORD_RW_SELF_PROGRAM_CONTROL 8'h9F
`define IORD_RW_SPH 8'h07
`define IORD_RW_WATCHDOG_CONTROL 8'h1F
`define IORD_RW_CLOCK_DIVIDER_CONTROL 8'h8F
`define IORD_RW_PRR 8'h1F
`define IORD_RW_EXT_IRQ_SENSE_CONFIG 8'h03

// Write-one-to-clear flag masks and flag positions
`define IORD_W1C_SERIAL_PERIPH_FLAGS 8'hC0
`define IORD_W1C_COMPARATOR_CONTROL 8'h10
`define IORD_SPI_DONE_BIT 7
`define IORD_SPI_COLL_BIT 6
`define IORD_CMP_EVENT_BIT 4

// Live read-only status bits
`define IORD_LIVE_CMP_OUT_BIT 5
`define IORD_LIVE_RWW_BUSY_BIT 6
`endif

// ### hw/iord_pkg.sv
package iord_pkg;
	// Access kinds issued by the core
	typedef enum logic [2:0] {
		IORD_OP_IO_IN,
		IORD_OP_IO_OUT,
		data_space_load_op,
		data_space_store_op,
		set_single_io_bit_op,
		clear_single_io_bit_op
	} iord_op_t;

	typedef struct packed {
		logic valid;
		iord_op_t op;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [2:0] bit_idx;
	} iord_req_t;

	typedef struct packed {
		logic ack;
		logic refused;
		logic [7:0] rdata;
	} iord_resp_t;

	typedef struct packed {
		logic [7:0] rw;
		logic [7:0] w1c;
		logic [7:0] live;
	} iord_mask_t;
endpackage

// ### sim/iord_core_model.sv
`timescale 1ns/1ps
module iord_core_model
	import iord_pkg::*;
(
	input wire logic clk,
	input iord_resp_t resp,
	output iord_req_t req
);
	// Idle until the first request
	initial req = '0;

	// One access: raise on an edge, drop on the taking edge, answer read after it lands
	// Bit index rides in wdata[2:0] to keep the call short
	task automatic access(input iord_op_t op, input logic [7:0] addr, input logic [7:0] wdata,
		output logic ack, output logic refused, output logic [7:0] rdata);
		@(posedge clk);
		req <= '{valid: 1'b1, op: op, addr: addr, wdata: wdata, bit_idx: wdata[2:0]};
		@(posedge clk);
		// Released fields inverted so a stale copy never looks like a fresh request
		req <= '{valid: 1'b0, op: op, addr: ~addr, wdata: ~wdata, bit_idx: ~wdata[2:0]};
		#1;
		ack = resp.ack;
		refused = resp.refused;
		rdata = resp.rdata;
	endtask
endmodule

// ### sim/tb.sv
`timescale 1ns/1ps
module tb;
	import iord_pkg::*;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic spi_done_set = 1'b0;
	logic spi_coll_set = 1'b0;
	logic cmp_event_set = 1'b0;
	logic cmp_out = 1'b0;
	logic rww_busy = 1'b0;
	iord_req_t core_req;
	iord_resp_t core_resp;
	logic [10:0] stack_ptr;
	logic [7:0] proc_flags;
	logic [7:0] spi_control;
	logic ack;
	logic refused;
	logic [7:0] rdata;
	int fails = 0;
	int n_checks = 0;

	iord_bank iord_bank_i (.REF_CLK(ref_clk), .ARST_N(arst_n), .CORE_REQ(core_req),
		.SPI_DONE_SET(spi_done_set), .SPI_COLL_SET(spi_coll_set),
		.CMP_EVENT_SET(cmp_event_set), .CMP_OUT(cmp_out), .RWW_BUSY(rww_busy),
		.CORE_RESP(core_resp), .STACK_PTR(stack_ptr), .PROC_FLAGS(proc_flags),
		.SPI_CONTROL(spi_control));
	iord_core_model iord_core_model_i (.clk(ref_clk), .resp(core_resp), .req(core_req));

	// 20 MHz clock
	always #25 ref_clk = ~ref_clk;

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Access plus judgement; writes and refusals must bring zero data
	task automatic acc(input string what, input iord_op_t op, input logic [7:0] addr,
		input logic [7:0] wdata, input logic exp_ref, input logic [7:0] exp_data);
		iord_core_model_i.access(op, addr, wdata, ack, refused, rdata);
		chk({what, " ack"}, 8'h01, {7'h00, ack});
		chk({what, " refused"}, {7'h00, exp_ref}, {7'h00, refused});
		chk({what, " data"}, exp_data, rdata);
	endtask

	task automatic t_map;
		acc("store 4C", data_space_store_op, 8'h4C, 8'h55, 1'b0, 8'h00);
		chk("spi control pins", 8'h55, spi_control);
		acc("in 2C", IORD_OP_IO_IN, 8'h2C, 8'h00, 1'b0, 8'h55);
		acc("out 3F", IORD_OP_IO_OUT, 8'h3F, 8'hA5, 1'b0, 8'h00);
		acc("load 5F", data_space_load_op, 8'h5F, 8'h00, 1'b0, 8'hA5);
		chk("flag pins", 8'hA5, proc_flags);
		acc("in 40", IORD_OP_IO_IN, 8'h40, 8'h00, 1'b1, 8'h00);
		acc("load 1F", data_space_load_op, 8'h1F, 8'h00, 1'b1, 8'h00);
		$display("test map done");
	endtask

	task automatic t_ext;
		acc("store 66", data_space_store_op, 8'h66, 8'h3C, 1'b0, 8'h00);
		acc("out 66", IORD_OP_IO_OUT, 8'h66, 8'hFF, 1'b1, 8'h00);
		acc("in 60", IORD_OP_IO_IN, 8'h60, 8'h00, 1'b1, 8'h00);
		acc("load 66", data_space_load_op, 8'h66, 8'h00, 1'b0, 8'h3C);
		$display("test extended done");
	endtask

	task automatic t_flags;
		@(posedge ref_clk);
		spi_done_set <= 1'b1;
		spi_coll_set <= 1'b1;
		cmp_event_set <= 1'b1;
		cmp_out <= 1'b1;
		rww_busy <= 1'b1;
		@(posedge ref_clk);
		spi_done_set <= 1'b0;
		spi_coll_set <= 1'b0;
		cmp_event_set <= 1'b0;
		acc("load 4D set", data_space_load_op, 8'h4D, 8'h00, 1'b0, 8'hC0);
		acc("store 4D zero", data_space_store_op, 8'h4D, 8'h00, 1'b0, 8'h00);
		acc("load 4D kept", data_space_load_op, 8'h4D, 8'h00, 1'b0, 8'hC0);
		acc("store 4D one", data_space_store_op, 8'h4D, 8'h80, 1'b0, 8'h00);
		acc("load 4D clear", data_space_load_op, 8'h4D, 8'h00, 1'b0, 8'h40);
		acc("store 4D coll", data_space_store_op, 8'h4D, 8'h40, 1'b0, 8'h00);
		acc("load 4D none", data_space_load_op, 8'h4D, 8'h00, 1'b0, 8'h00);
		// Clear and set pulse meet on one edge; the set must survive
		fork
			acc("store 4D race", data_space_store_op, 8'h4D, 8'h80, 1'b0, 8'h00);
			begin
				@(posedge ref_clk);
				spi_done_set <= 1'b1;
				@(posedge ref_clk);
				spi_done_set <= 1'b0;
			end
		join
		acc("load 4D race", data_space_load_op, 8'h4D, 8'h00, 1'b0, 8'h80);
		acc("load 50 set", data_space_load_op, 8'h50, 8'h00, 1'b0, 8'h30);
		acc("store 50 one", data_space_store_op, 8'h50, 8'h10, 1'b0, 8'h00);
		acc("load 50 clear", data_space_load_op, 8'h50, 8'h00, 1'b0, 8'h20);
		// Busy bit is live; the reserved bit beside it stays low though its input is high
		acc("load 57 busy", data_space_load_op, 8'h57, 8'h00, 1'b0, 8'h40);
		$display("test flags done");
	endtask

	task automatic t_bits;
		acc("set 05", set_single_io_bit_op, 8'h05, 8'h01, 1'b1, 8'h00);
		acc("clear 1F", clear_single_io_bit_op, 8'h1F, 8'h07, 1'b1, 8'h00);
		acc("set 2C", set_single_io_bit_op, 8'h2C, 8'h01, 1'b1, 8'h00);
		acc("clear 2C", clear_single_io_bit_op, 8'h2C, 8'h02, 1'b1, 8'h00);
		acc("in 2C kept", IORD_OP_IO_IN, 8'h2C, 8'h00, 1'b0, 8'h55);
		$display("test bit ops done");
	endtask

	task automatic t_reserved;
		acc("load 4F", data_space_load_op, 8'h4F, 8'h00, 1'b1, 8'h00);
		acc("in 2F", IORD_OP_IO_IN, 8'h2F, 8'h00, 1'b1, 8'h00);
		acc("store 5E", data_space_store_op, 8'h5E, 8'h05, 1'b0, 8'h00);
		chk("stack pointer high", 8'h05, {5'h00, stack_ptr[10:8]});
		acc("load 5E", data_space_load_op, 8'h5E, 8'h00, 1'b0, 8'h05);
		acc("store 5D", data_space_store_op, 8'h5D, 8'h3A, 1'b0, 8'h00);
		chk("stack pointer low", 8'h3A, stack_ptr[7:0]);
		$display("test reserved done");
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Main sequence after three reset cycles
	initial begin
		repeat (3) @(posedge ref_clk);
		arst_n <= 1'b1;
		t_map();
		t_ext();
		t_flags();
		t_bits();
		t_reserved();
		tally_and_finish();
	end

	// Tests need some 70 cycles; 2000 cycles means a hang
	initial begin
		#100000;
		fails++;
		tally_and_finish();
	end
endmodule
